// >>> hdl/msi_pkg.sv
/*
 Constants and types for the product and saturating-arithmetic pipeline timing control.
 Assumes a core decoder that classifies instructions and names their registers.
*/
// How it works
// RULE1: Product result usable only after Memory ends
// RULE2: Stall consumer needing product in Execute/Memory
// RULE3: Accumulator chaining on previous product never stalls
// RULE4: Basic product: I,S; interlocked I,I,S
// RULE5: Flag-setting basic product: I,I,I,S, no interlock
// RULE6: Long product: I,I,S; interlocked I,I,I,S
// RULE7: Flag-setting long product: four I then S
// RULE8: Halfword product: S; interlocked I,S
// RULE9: Halfword long accumulate: I,S; interlocked I,I,S
// RULE10: Saturating ops one cycle, 32-bit state only
// RULE11: Saturating result needed in Execute stalls
// RULE12: Saturating result needed in Memory never stalls
// RULE13: Saturating: S; interlocked I then S
// RULE14: All product cycles but last internal, data idle
// RULE15: Booth stage consumes 16 multiplier bits per cycle
// RULE16: Compare Execute destination with Decode sources, hold fetch
package msi_pkg;
    localparam int REG_W = 4;
    localparam int BOOTH_BITS = 16;
    localparam logic [2:0] BASE_BASIC = 3'h2;
    localparam logic [2:0] BASE_BASIC_FLAGS = 3'h4;
    localparam logic [2:0] BASE_LONG = 3'h3;
    localparam logic [2:0] BASE_LONG_FLAGS = 3'h5;
    localparam logic [2:0] BASE_HALF = 3'h1;
    localparam logic [2:0] BASE_HALF_LONG = 3'h2;
    localparam logic [2:0] BASE_SAT = 3'h1;

    // Instruction classes handed in by the decoder
    typedef enum logic [3:0] {
        OTHER_OP,
        PRODUCT_OP,
        PRODUCT_ACCUMULATE_OP,
        PRODUCT_FLAGS_OP,
        PRODUCT_ACCUMULATE_FLAGS_OP,
        LONG_PRODUCT,
        LONG_PRODUCT_ACCUMULATE,
        LONG_PRODUCT_FLAGS,
        LONG_ACCUMULATE_FLAGS,
        HALFWORD_PRODUCT,
        HALFWORD_ACCUMULATE,
        HALFWORD_LONG_ACCUMULATE,
        SATURATING_OP
    } msi_class_t;

    // Decoded instruction as seen by the timing control
    typedef struct packed {
        logic valid;
        msi_class_t cls;
        logic [REG_W-1:0] dest;
        logic [REG_W-1:0] src_exec_a;
        logic src_exec_a_used;
        logic [REG_W-1:0] src_exec_b;
        logic src_exec_b_used;
        logic [REG_W-1:0] src_mem;
        logic src_mem_used;
        logic mem_is_accum;
        logic wide_state;
    } msi_fetched_opcode_t;

    // Cycle type on the fetch and data sides
    typedef struct packed {
        logic fetch_request_n;
        logic fetch_sequential;
        logic data_request_n;
        logic data_sequential;
    } msi_bus_t;
endpackage : msi_pkg

// >>> hdl/msi_timing.sv
/*
 Execute-stage timing and interlock control for product and saturating instructions.
 Assumes the decoder presents the Decode-stage instruction and advances on ISSUE_OUT.
*/
`timescale 1ns/1ps
module msi_timing
(
    input wire logic CLOCK_IN, // Core clock
    input wire logic SYS_RST_IN, // Async reset, high
    input wire msi_pkg::msi_fetched_opcode_t DECODE_IN, // Instruction in Decode
    output msi_pkg::msi_bus_t BUS_OUT, // Cycle type on both sides
    output logic HOLD_FETCH_OUT, // Keep fetch address
    output logic ISSUE_OUT, // Decode moves to Execute
    output logic STALL_OUT, // Interlock cycle inserted
    output logic UNDEF_OUT, // Saturating op in narrow state
    output logic [2:0] BOOTH_STEP_OUT, // Booth step, 16 bits each
    output logic RESULT_READY_OUT // Late product or saturating result leaves Memory
);

    ////////////////////////////////////////////////////////////////////////////
    // Execute-stage occupant
    msi_pkg::msi_fetched_opcode_t exec_r;
    logic [2:0] left_r;
    logic [2:0] left_nxt;
    logic in_mem_r;
    logic mem_prod_r;
    logic hazard;
    logic producer;
    logic late_class;
    logic exec_match;
    logic mem_match;
    logic sat_in_exec;
    logic internal_cycle;
    logic busy;
    logic issue;
    logic [2:0] base;

    // Base execute length per class
    always_comb
    begin
        base = 3'h1;
        unique case (DECODE_IN.cls)
            msi_pkg::PRODUCT_OP, msi_pkg::PRODUCT_ACCUMULATE_OP:
                base = msi_pkg::BASE_BASIC; // RULE4
            msi_pkg::PRODUCT_FLAGS_OP, msi_pkg::PRODUCT_ACCUMULATE_FLAGS_OP:
                base = msi_pkg::BASE_BASIC_FLAGS; // RULE5
            msi_pkg::LONG_PRODUCT, msi_pkg::LONG_PRODUCT_ACCUMULATE:
                base = msi_pkg::BASE_LONG; // RULE6
            msi_pkg::LONG_PRODUCT_FLAGS, msi_pkg::LONG_ACCUMULATE_FLAGS:
                base = msi_pkg::BASE_LONG_FLAGS; // RULE7
            msi_pkg::HALFWORD_PRODUCT, msi_pkg::HALFWORD_ACCUMULATE:
                base = msi_pkg::BASE_HALF; // RULE8
            msi_pkg::HALFWORD_LONG_ACCUMULATE:
                base = msi_pkg::BASE_HALF_LONG; // RULE9
            msi_pkg::SATURATING_OP:
                base = msi_pkg::BASE_SAT; // RULE10
            msi_pkg::OTHER_OP:
                base = 3'h1;
            default:
                base = 3'h1; // Codes past the last class
        endcase
    end

    // Late-result classes; flag-setting forms finish internally, so they hand nothing on
    always_comb
    begin
        late_class = 1'b0;
        unique case (exec_r.cls)
            msi_pkg::PRODUCT_OP, msi_pkg::PRODUCT_ACCUMULATE_OP:
                late_class = 1'b1; // RULE1
            msi_pkg::LONG_PRODUCT, msi_pkg::LONG_PRODUCT_ACCUMULATE:
                late_class = 1'b1; // RULE1
            msi_pkg::HALFWORD_PRODUCT, msi_pkg::HALFWORD_ACCUMULATE:
                late_class = 1'b1; // RULE1
            msi_pkg::HALFWORD_LONG_ACCUMULATE:
                late_class = 1'b1; // RULE1
            msi_pkg::SATURATING_OP:
                late_class = 1'b1; // RULE11
            msi_pkg::PRODUCT_FLAGS_OP, msi_pkg::PRODUCT_ACCUMULATE_FLAGS_OP:
                late_class = 1'b0; // RULE5
            msi_pkg::LONG_PRODUCT_FLAGS, msi_pkg::LONG_ACCUMULATE_FLAGS:
                late_class = 1'b0; // RULE7
            msi_pkg::OTHER_OP:
                late_class = 1'b0;
            default:
                late_class = 1'b0; // Codes past the last class
        endcase
    end

    // Only a valid late-result occupant of Execute can interlock
    assign producer = exec_r.valid && late_class;

    // Decode sources against the Execute destination
    always_comb
    begin
        exec_match = (DECODE_IN.src_exec_a_used && DECODE_IN.src_exec_a == exec_r.dest)
            || (DECODE_IN.src_exec_b_used && DECODE_IN.src_exec_b == exec_r.dest);
        mem_match = DECODE_IN.src_mem_used && DECODE_IN.src_mem == exec_r.dest;
        sat_in_exec = (exec_r.cls == msi_pkg::SATURATING_OP);
    end

    // Hazard; a saturating result still reaches a Memory-stage user in time
    always_comb
    begin
        hazard = 1'b0;
        if (producer && DECODE_IN.valid)
        begin
            if (exec_match)
                hazard = 1'b1; // RULE2 RULE11 RULE16
            else if (mem_match && !sat_in_exec) // RULE12
                hazard = !DECODE_IN.mem_is_accum; // RULE2 RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing: stall cycles are internal cycles added ahead of issue
    assign busy = (left_r > 3'h1);
    assign issue = DECODE_IN.valid && !busy && !(hazard && left_r == 3'h1);
    assign STALL_OUT = !busy && hazard && left_r == 3'h1; // RULE16

    always_comb
    begin
        left_nxt = left_r;
        if (busy)
            left_nxt = left_r - 3'h1;
        else if (STALL_OUT)
            left_nxt = 3'h0;
        else if (issue)
            left_nxt = base;
        else
            left_nxt = 3'h1;
    end

    // Count of remaining execute cycles
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            left_r <= 3'h1;
        else
            left_r <= left_nxt;
    end

    // Instruction register of Execute; its valid bit is cleared by a stall bubble
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            exec_r <= '0;
        else if (issue)
            exec_r <= DECODE_IN;
        else if (STALL_OUT)
            exec_r.valid <= 1'b0; // Producer now in Memory, result comes after
    end

    // Memory-stage occupancy; result usable only once Memory ends
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            in_mem_r <= 1'b0;
        else
            in_mem_r <= !busy && exec_r.valid; // RULE1
    end

    // Whether that occupant hands on a late result
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            mem_prod_r <= 1'b0;
        else
            mem_prod_r <= producer;
    end
    assign RESULT_READY_OUT = in_mem_r && mem_prod_r; // RULE1

    // Booth step counter, one step of 16 bits per cycle
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            BOOTH_STEP_OUT <= 3'h0;
        else if (issue)
            BOOTH_STEP_OUT <= 3'h0;
        else if (busy)
            BOOTH_STEP_OUT <= BOOTH_STEP_OUT + 3'h1; // RULE15
    end

    ////////////////////////////////////////////////////////////////////////////
    // One internal-cycle flag feeds both fetch fields and the hold
    assign internal_cycle = busy || STALL_OUT;

    // Bus cycle types: internal until the last cycle, which fetches sequentially
    always_comb
    begin
        BUS_OUT.fetch_request_n = internal_cycle; // RULE14 RULE13
        BUS_OUT.fetch_sequential = !internal_cycle; // RULE4 RULE8
        BUS_OUT.data_request_n = 1'b1; // RULE14
        BUS_OUT.data_sequential = 1'b0; // Data side idles as I cycles
    end
    assign HOLD_FETCH_OUT = internal_cycle; // RULE16
    assign ISSUE_OUT = issue;
    assign UNDEF_OUT = issue && DECODE_IN.cls == msi_pkg::SATURATING_OP
        && !DECODE_IN.wide_state; // RULE10

endmodule : msi_timing

// >>> verification/msi_checker.sv
/* Port assertions for the product timing control.
 Bound from the bench; sees only the top ports. */
`timescale 1ns/1ps
module msi_checker
(
    input wire logic CLOCK_IN, // Clock
    input wire logic SYS_RST_IN, // Reset
    input wire msi_pkg::msi_fetched_opcode_t DECODE_IN, // Decode
    input wire msi_pkg::msi_bus_t BUS_OUT, // Cycle types
    input wire logic HOLD_FETCH_OUT, // Hold
    input wire logic ISSUE_OUT, // Issue
    input wire logic STALL_OUT, // Bubble
    input wire logic UNDEF_OUT // Undefined
);
    default clocking @(posedge CLOCK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    // Class issued; an idle slot reads as a plain op
    msi_pkg::msi_class_t iss;
    assign iss = ISSUE_OUT ? DECODE_IN.cls : msi_pkg::OTHER_OP;
    wire logic busy = BUS_OUT.fetch_request_n && !ISSUE_OUT;
    wire logic calm = busy && !STALL_OUT;
    ////////////////////////////////////////
    idle_data_a: assert property (BUS_OUT.data_request_n && !BUS_OUT.data_sequential)
        else $error("data side active");
    mul_busy_a: assert property (iss == msi_pkg::PRODUCT_OP |=> busy)
        else $error("basic product too short");
    long_busy_a: assert property (iss == msi_pkg::LONG_PRODUCT |=> busy[*2])
        else $error("long product too short");
    flag_run_a: assert property (iss == msi_pkg::PRODUCT_FLAGS_OP |=> calm[*3] ##1 !STALL_OUT)
        else $error("flag product timing");
    lflag_run_a: assert property (iss == msi_pkg::LONG_PRODUCT_FLAGS |=> calm[*4] ##1 !STALL_OUT)
        else $error("flag long product timing");
    stall_hold_a: assert property (STALL_OUT |-> busy && HOLD_FETCH_OUT)
        else $error("bubble not internal");
    sat_mem_a: assert property (iss == msi_pkg::SATURATING_OP ##1 !DECODE_IN.src_exec_b_used &&
        DECODE_IN.src_exec_a != $past(DECODE_IN.dest) |-> !STALL_OUT)
        else $error("saturating store stalled");
    undef_sat_a: assert property (UNDEF_OUT |-> !DECODE_IN.wide_state)
        else $error("undefined flag wrong");
    cover property (STALL_OUT);
    cover property (iss == msi_pkg::LONG_ACCUMULATE_FLAGS);
    cover property (UNDEF_OUT);
endmodule : msi_checker

// >>> verification/msi_mem_model.sv
/* Memory side: serves a fetch on each S cycle.
 Assumes one core clock and the package bus struct. */
`timescale 1ns/1ps
module msi_mem_model
(
    input wire logic CLOCK_IN, // Core clock
    input wire logic SYS_RST_IN, // Async reset
    input wire msi_pkg::msi_bus_t BUS_IN, // Cycle types
    output logic [15:0] seq_count_out // Fetches served
);
    // I cycles fetch nothing, so the address may stand
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
        if (SYS_RST_IN)
            seq_count_out <= 16'h0;
        else if (!BUS_IN.fetch_request_n && BUS_IN.fetch_sequential)
            seq_count_out <= seq_count_out + 16'h1;
endmodule : msi_mem_model

// >>> verification/multiply_saturate_interlock_timing_tb.sv
/* Bench: stands in for the decoder, counts cycles per issue.
 Assumes the memory model and checker files are compiled first. */
`timescale 1ns/1ps
module multiply_saturate_interlock_timing_tb;
    logic CLOCK_IN = 1'h0;
    logic SYS_RST_IN = 1'h1;
    msi_pkg::msi_fetched_opcode_t DECODE_IN = '0;
    msi_pkg::msi_fetched_opcode_t prev = '0;
    msi_pkg::msi_bus_t BUS_OUT;
    logic HOLD_FETCH_OUT, ISSUE_OUT, STALL_OUT, UNDEF_OUT, RESULT_READY_OUT;
    logic [2:0] BOOTH_STEP_OUT;
    logic [15:0] seq_cnt;
    int fail_count = 0, checks_done = 0, cycles = 0;
    // Base cycles per class; mask of late product results
    logic [2:0] base_t [13] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h3, 3'h3, 3'h5, 3'h5, 3'h1,
        3'h1, 3'h2, 3'h1};
    logic [12:0] prod_m = 13'h0e66;
    msi_timing i_dut (.CLOCK_IN, .SYS_RST_IN, .DECODE_IN, .BUS_OUT, .HOLD_FETCH_OUT,
        .ISSUE_OUT, .STALL_OUT, .UNDEF_OUT, .BOOTH_STEP_OUT, .RESULT_READY_OUT);
    msi_mem_model i_mem (.CLOCK_IN, .SYS_RST_IN, .BUS_IN(BUS_OUT), .seq_count_out(seq_cnt));
    initial forever #2.5 CLOCK_IN = ~CLOCK_IN;
    // Hang guard, far above the thousand or so cycles needed
    always @(posedge CLOCK_IN) if (++cycles == 20000) conclude(1'h1);
    ////////////////////////////////////////
    task automatic conclude(input logic hang);
        fail_count += hang;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        fail_count += (e !== g);
        if (e !== g) $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    endtask : check
    // Stall expected when the late result feeds the consumer
    function automatic logic hazard(input msi_pkg::msi_fetched_opcode_t p, input msi_pkg::msi_fetched_opcode_t c);
        logic ex, mem;
        ex = c.src_exec_a_used && c.src_exec_a == p.dest || c.src_exec_b_used && c.src_exec_b == p.dest;
        mem = c.src_mem_used && c.src_mem == p.dest && !c.mem_is_accum;
        return ex && (prod_m[p.cls] || p.cls == msi_pkg::SATURATING_OP) || mem && prod_m[p.cls];
    endfunction : hazard
    function automatic msi_pkg::msi_fetched_opcode_t mk(input int c, d, a, m, acc);
        return '{valid: 1'h1, cls: msi_pkg::msi_class_t'(c), dest: 4'(d), src_exec_a: 4'(a),
            src_exec_a_used: 1'h1, src_mem: 4'(m), src_mem_used: 1'h1, mem_is_accum: 1'(acc),
            wide_state: 1'h1, default: '0};
    endfunction : mk
    // Present one op, count cycles, stalls and fetches to its issue
    task automatic send(input msi_pkg::msi_fetched_opcode_t c);
        int n = 0;
        int st = 0;
        logic [15:0] s0 = seq_cnt;
        int hold = 0;
        logic und = 1'h0;
        logic [2:0] bs = 3'h0;
        DECODE_IN = c;
        do
        begin
            @(negedge CLOCK_IN);
            n++;
            st += (STALL_OUT === 1'h1);
            hold += (HOLD_FETCH_OUT === 1'h1);
            und = UNDEF_OUT;
            bs = BOOTH_STEP_OUT;
        end
        while (ISSUE_OUT !== 1'h1 && n < 20);
        @(posedge CLOCK_IN);
        #1;
        check("cycles", 8'(base_t[prev.cls] + hazard(prev, c)), 8'(n));
        check("stalls", 8'(hazard(prev, c)), 8'(st));
        check("s fetches", 8'h1, 8'(seq_cnt - s0));
        check("holds", 8'(base_t[prev.cls] - 1 + hazard(prev, c)), 8'(hold));
        check("undef", 8'(c.cls == msi_pkg::SATURATING_OP && !c.wide_state), 8'(und));
        check("booth step", 8'(base_t[prev.cls] - 1), 8'(bs));
        check("result ready", 8'((prod_m[prev.cls] || prev.cls == msi_pkg::SATURATING_OP)
            && !hazard(prev, c)), 8'(RESULT_READY_OUT));
        prev = c;
    endtask : send
    initial
    begin
        msi_pkg::msi_fetched_opcode_t r;
        void'($urandom(32'h1384));
        repeat (12) @(posedge CLOCK_IN);
        #1;
        SYS_RST_IN = 1'h0;
        // Each class before execute, store and accumulator users
        for (int k = 0; k < 13; k++)
        begin
            send(mk(k, 0, 1, 2, 0));
            send(mk(0, 1, 0, 2, 0));
            send(mk(k, 0, 1, 2, 0));
            send(mk(0, 1, 3, 0, 0));
            send(mk(k, 0, 1, 2, 0));
            send(mk(2, 1, 3, 0, 1));
        end
        // Random classes over three registers to force overlaps
        repeat (300)
        begin
            r = mk($urandom_range(0, 12), $urandom_range(0, 2), $urandom_range(0, 2), 3, 0);
            r.src_exec_a_used = 1'($urandom);
            r.src_exec_b = 4'($urandom_range(0, 2));
            r.src_exec_b_used = 1'($urandom);
            r.mem_is_accum = r.cls == msi_pkg::PRODUCT_ACCUMULATE_OP;
            r.src_mem = 4'($urandom_range(0, 2));
            r.src_mem_used = 1'($urandom) && r.cls inside {msi_pkg::OTHER_OP, msi_pkg::PRODUCT_ACCUMULATE_OP};
            send(r);
        end
        // Saturating op in the narrow state
        send(mk(12, 3, 3, 3, 0) & ~26'h1);
        DECODE_IN.valid = 1'h0;
        repeat (8) @(posedge CLOCK_IN);
        conclude(1'h0);
    end
endmodule : multiply_saturate_interlock_timing_tb
bind msi_timing msi_checker i_chk (.CLOCK_IN, .SYS_RST_IN, .DECODE_IN, .BUS_OUT,
    .HOLD_FETCH_OUT, .ISSUE_OUT, .STALL_OUT, .UNDEF_OUT);
